// *** hlr_responder.sv ***
// Host link frame checker and end code generator
//
// Function
// - Only the end code of the first detected error is returned.
// - Commands invalid in run mode answer end code 01.
// - Commands invalid in monitor mode answer end code 02.
// - Program memory changes while software write-protected answer 03.
// - Set-value program address above 65535 answers 04.
// - Check sequence mismatch in single or first frame answers 13.
// - Bad format or split unsplittable command answers 14.
// - Data out of range or too long answers 15.
// - Set-value operand missing from program answers 16.
// - Single or first frame over 132 bytes answers 18.
// - Batch read with nothing registered answers 19.
// - Memory change while write-protect switch is on answers 23.
// - Check sequence mismatch in later frame aborts with A3.
// - Later frame byte count disagreeing with format aborts with A4.
// - Data error in later frame aborts with A5.
// - Later frame over 132 bytes aborts with A8.
// - No carriage return in 280 bytes sets overflow flag, silent.
// - Line errors set error flag and code, reset reception silently.
// - First frame not starting with start character is silently dropped.
// - Wrong, non-hex or over-31 node number is silently dropped.
// - Later write frame with one or two data bytes is check error.
// - Communications error indication is one status bit.
// - Port error code is a four-bit status field.
`include "hlr_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module hlr_responder (
  input  wire logic              core_clk_i,       // Core clock, 125 MHz
  input  wire logic              reset_n_i,        // Synchronous reset, active low
  input  wire logic              rx_valid_i,       // Received byte valid
  input  wire logic [7:0]        rx_data_i,        // Received byte
  output logic                   rx_ready_o,       // Byte accepted
  input  wire logic              rx_err_i,         // Line error pulse
  input  wire hlr_pkg::hlr_rxerr_t rx_err_kind_i,  // Kind of line error
  input  wire logic [4:0]        node_id_i,        // Own node number
  input  wire hlr_pkg::hlr_mode_t mode_i,          // Operating mode
  input  wire logic              pm_protect_i,     // Program memory protected
  input  wire logic              wp_switch_i,      // Write-protect switch
  input  wire logic              sv_addr_over_i,   // Set-value address too high
  input  wire logic              operand_miss_i,   // Operand not in program
  input  wire logic              data_err_i,       // Data out of range
  input  wire logic              rd_registered_i,  // Batch items registered
  output logic                   body_valid_o,     // Body byte available
  input  wire logic              body_ready_i,     // Body byte taken
  output logic [7:0]             body_data_o,      // Body byte
  output logic                   resp_valid_o,     // Response pulse
  output logic                   resp_more_o,      // Intermediate frame ack
  output logic [15:0]            end_code_o,       // End code, two ASCII chars
  output logic                   comm_err_o,       // Communications error bit
  output logic [3:0]             port_err_code_o,  // Port error code field
  output logic                   rx_overflow_o     // Reception overflow bit
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // ASCII hex digit to {valid, value}
  function automatic logic [4:0] hex_dec(input logic [7:0] c);
    logic [4:0] r;
    r = 5'h00;
    if (c >= 8'h30 && c <= 8'h39)
      r = {1'b1, c[3:0]};
    else if (c >= 8'h41 && c <= 8'h46)
      r = {1'b1, c[3:0] + 4'h9};
    return r;
  endfunction

  // Nibble to ASCII hex digit
  function automatic logic [7:0] hex_enc(input logic [3:0] n);
    logic [7:0] r;
    r = (n < 4'hA) ? {4'h3, n} : {4'h4, n - 4'h9};
    return r;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------

  hlr_pkg::hlr_state_t state_r;
  logic        first_r;      // Waiting for a single or first frame
  logic [8:0]  cnt_r;        // Bytes in current frame
  logic [7:0]  x_r [4];      // Running check value history
  logic [7:0]  b1_r;         // Last byte
  logic [7:0]  b2_r;
  logic [7:0]  b3_r;
  logic [7:0]  hdr0_r;
  logic [7:0]  hdr1_r;
  logic [7:0]  dat0_r;
  logic [7:0]  dat1_r;
  logic        err_v_r;      // An error is already latched
  logic [7:0]  err_r;
  logic        resp_valid_r;
  logic        resp_more_r;
  logic [7:0]  code_r;
  logic        comm_err_r;
  logic [3:0]  perr_r;
  logic        ovf_r;

  // ----------------------------------------------------------------
  // Byte decode
  // ----------------------------------------------------------------

  wire        fifo_in_ready;
  wire        acc      = rx_valid_i & rx_ready_o & ~rx_err_i;
  wire        is_cr    = (rx_data_i == `HLR_CH_CR);
  wire        in_body  = (state_r == hlr_pkg::HLR_ST_BODY);
  wire        in_idle  = (state_r == hlr_pkg::HLR_ST_IDLE);
  wire [8:0]  cnt_nxt  = cnt_r + 9'h001;
  wire [7:0]  x_nxt    = x_r[0] ^ rx_data_i;
  wire        hdr_done = ~first_r | (cnt_r >= `HLR_HDR_LEN);

  // Node number from previous and current byte
  wire [4:0]  node_hi  = hex_dec(b1_r);
  wire [4:0]  node_lo  = hex_dec(rx_data_i);
  wire [7:0]  node_val = {node_hi[3:0], node_lo[3:0]};
  wire        node_bad = ~node_hi[4] | ~node_lo[4] | (node_val > `HLR_NODE_MAX)
                         | (node_val[4:0] != node_id_i);
  wire        node_chk = acc & in_body & first_r & (cnt_r == 9'h002) & ~is_cr;

  // Frame limits
  wire        len_over = acc & in_body & ~is_cr & (cnt_r == `HLR_FRAME_MAX);
  wire        ovf_hit  = acc & in_body & ~is_cr & (cnt_r == `HLR_OVF_LIMIT - 9'h001);

  // ----------------------------------------------------------------
  // Frame end evaluation
  // ----------------------------------------------------------------

  wire        frm_end  = acc & in_body & is_cr;
  wire        is_last  = (b1_r == `HLR_CH_TERM);
  wire [8:0]  trail    = is_last ? 9'h003 : 9'h002;
  wire [8:0]  hdr_len  = first_r ? `HLR_HDR_LEN : 9'h000;
  wire        too_short = (cnt_r < hdr_len + trail);
  wire [8:0]  dlen     = too_short ? 9'h000 : cnt_r - hdr_len - trail;

  // Received and computed check values
  wire [4:0]  chk_hi   = is_last ? hex_dec(b3_r) : hex_dec(b2_r);
  wire [4:0]  chk_lo   = is_last ? hex_dec(b2_r) : hex_dec(b1_r);
  wire [7:0]  chk_calc = is_last ? x_r[3] : x_r[2];
  wire        chk_bad  = ~chk_hi[4] | ~chk_lo[4]
                         | ({chk_hi[3:0], chk_lo[3:0]} != chk_calc);

  // Command classes from header and leading data characters
  wire        h_w      = (hdr0_r == `HLR_CH_W);
  wire        h_sv     = (hdr1_r == `HLR_CH_HASH) | (hdr1_r == `HLR_CH_DOLLAR)
                         | (hdr1_r == `HLR_CH_PCT);
  wire        c_sv     = (h_w | (hdr0_r == `HLR_CH_R)) & h_sv;
  wire        c_prog   = (h_w & (hdr1_r == `HLR_CH_P))
                         | ((hdr0_r == `HLR_CH_M) & (hdr1_r == `HLR_CH_I));
  wire        c_force  = ((hdr0_r == `HLR_CH_K) & ((hdr1_r == `HLR_CH_S)
                         | (hdr1_r == `HLR_CH_R) | (hdr1_r == `HLR_CH_C)))
                         | ((hdr0_r == `HLR_CH_F) & (hdr1_r == `HLR_CH_K));
  wire        c_write  = h_w | c_force;
  wire        c_pm     = c_prog | (h_w & h_sv);
  wire        c_qqread = (hdr0_r == `HLR_CH_Q) & (hdr1_r == `HLR_CH_Q)
                         & (dat0_r == `HLR_CH_I) & (dat1_r == `HLR_CH_R);
  wire        run_bad  = (c_write | c_prog) & (mode_i == hlr_pkg::HLR_MODE_RUN);
  wire        mon_bad  = c_prog & (mode_i == hlr_pkg::HLR_MODE_MON);

  // Single or first frame: fixed detection order
  logic [7:0] first_code;
  always_comb
  begin
    if (chk_bad)
      first_code = `HLR_EC_CHK;
    else if (too_short | (~is_last & ~c_write))
      first_code = `HLR_EC_FMT;
    else if (run_bad)
      first_code = `HLR_EC_RUN;
    else if (mon_bad)
      first_code = `HLR_EC_MON;
    else if (c_pm & pm_protect_i)
      first_code = `HLR_EC_PM_WP;
    else if (c_pm & wp_switch_i)
      first_code = `HLR_EC_SW_WP;
    else if (c_sv & sv_addr_over_i)
      first_code = `HLR_EC_ADDR;
    else if (data_err_i)
      first_code = `HLR_EC_DATA;
    else if (c_sv & operand_miss_i)
      first_code = `HLR_EC_OPND;
    else if (c_qqread & ~rd_registered_i)
      first_code = `HLR_EC_NOREG;
    else
      first_code = `HLR_EC_OK;
  end

  // Later frame of a split command
  logic [7:0] later_code;
  always_comb
  begin
    if (chk_bad | (c_write & ((dlen == 9'h001) | (dlen == 9'h002))))
      later_code = `HLR_EC_AB_CHK;
    else if (too_short | (dlen[1:0] != `HLR_WORD_CHARS))
      later_code = `HLR_EC_AB_FMT;
    else if (data_err_i)
      later_code = `HLR_EC_AB_DATA;
    else
      later_code = `HLR_EC_OK;
  end

  // Earlier latched error wins over anything found at the end
  wire [7:0]  end_code = err_v_r ? err_r : (first_r ? first_code : later_code);
  wire        end_ok   = (end_code == `HLR_EC_OK);

  // Line error to port error code
  wire [3:0]  perr_nxt = (rx_err_kind_i == hlr_pkg::HLR_RXE_PARITY)  ? `HLR_PERR_PAR :
                         (rx_err_kind_i == hlr_pkg::HLR_RXE_OVERRUN) ? `HLR_PERR_OVR :
                                                                       `HLR_PERR_FRM;

  // Body bytes go to the FIFO once the header is through
  wire        push     = acc & in_body & ~is_cr & hdr_done;
  wire        push_idl = acc & in_idle & ~first_r;

  // ----------------------------------------------------------------
  // Body FIFO
  // ----------------------------------------------------------------

  // Whole stream stalls while the FIFO is full
  assign rx_ready_o = fifo_in_ready;

  hlr_fifo #(
    .WIDTH (`HLR_FIFO_WIDTH),
    .DEPTH (`HLR_FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i  (core_clk_i),
    .reset_n_i   (reset_n_i),
    .in_valid_i  (push | push_idl),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (rx_data_i),
    .out_valid_o (body_valid_o),
    .out_ready_i (body_ready_i),
    .out_data_o  (body_data_o)
  );

  // ----------------------------------------------------------------
  // Reception sequencer
  // ----------------------------------------------------------------

  // Frame state, byte count and first-frame tracking
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      state_r <= hlr_pkg::HLR_ST_IDLE;
      first_r <= 1'b1;
      cnt_r   <= 9'h000;
    end
    else if (rx_err_i)
    begin
      state_r <= hlr_pkg::HLR_ST_IDLE;
      first_r <= 1'b1;
      cnt_r   <= 9'h000;
    end
    else if (acc)
    begin
      case (state_r)
        hlr_pkg::HLR_ST_IDLE:
        begin
          cnt_r <= 9'h001;
          if (first_r & (rx_data_i != `HLR_CH_START))
            state_r <= hlr_pkg::HLR_ST_DISCARD;
          else if (~is_cr)
            state_r <= hlr_pkg::HLR_ST_BODY;
        end
        hlr_pkg::HLR_ST_BODY:
        begin
          cnt_r <= cnt_nxt;
          if (is_cr)
          begin
            state_r <= hlr_pkg::HLR_ST_IDLE;
            first_r <= ~end_ok | is_last;
            cnt_r   <= 9'h000;
          end
          else if (ovf_hit | (node_chk & node_bad))
          begin
            state_r <= hlr_pkg::HLR_ST_DISCARD;
            first_r <= 1'b1;
          end
        end
        hlr_pkg::HLR_ST_DISCARD:
        begin
          if (is_cr)
          begin
            state_r <= hlr_pkg::HLR_ST_IDLE;
            cnt_r   <= 9'h000;
          end
        end
        default:
        begin
          state_r <= hlr_pkg::HLR_ST_IDLE;
          first_r <= 1'b1;
          cnt_r   <= 9'h000;
        end
      endcase
    end
  end

  // Check value history and recent bytes
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      x_r  <= '{default: 8'h00};
      b1_r <= 8'h00;
      b2_r <= 8'h00;
      b3_r <= 8'h00;
    end
    else if (acc)
    begin
      x_r  <= in_idle ? '{rx_data_i, 8'h00, 8'h00, 8'h00}
                      : '{x_nxt, x_r[0], x_r[1], x_r[2]};
      b1_r <= rx_data_i;
      b2_r <= in_idle ? 8'h00 : b1_r;
      b3_r <= in_idle ? 8'h00 : b2_r;
    end
  end

  // Header and leading data characters of the first frame
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      hdr0_r <= 8'h00;
      hdr1_r <= 8'h00;
      dat0_r <= 8'h00;
      dat1_r <= 8'h00;
    end
    else if (acc & in_body & first_r)
    begin
      if (cnt_r == 9'h003)
        hdr0_r <= rx_data_i;
      if (cnt_r == 9'h004)
        hdr1_r <= rx_data_i;
      if (cnt_r == 9'h005)
        dat0_r <= rx_data_i;
      if (cnt_r == 9'h006)
        dat1_r <= rx_data_i;
    end
  end

  // Length error latched as soon as it is seen
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i | rx_err_i | (acc & ~in_body))
    begin
      err_v_r <= 1'b0;
      err_r   <= `HLR_EC_OK;
    end
    else if (len_over & ~err_v_r)
    begin
      err_v_r <= 1'b1;
      err_r   <= first_r ? `HLR_EC_LEN : `HLR_EC_AB_LEN;
    end
  end

  // ----------------------------------------------------------------
  // Response and status
  // ----------------------------------------------------------------

  // One response per completed frame, silent on dropped frames
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      resp_valid_r <= 1'b0;
      resp_more_r  <= 1'b0;
      code_r       <= `HLR_EC_OK;
    end
    else
    begin
      resp_valid_r <= frm_end & ~rx_err_i;
      resp_more_r  <= frm_end & ~rx_err_i & end_ok & ~is_last;
      if (frm_end & ~rx_err_i)
      begin
        code_r      <= end_code;
      end
    end
  end

  // Sticky status bits; a new error wins over the clear
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      comm_err_r <= 1'b0;
      perr_r     <= `HLR_PERR_NONE;
      ovf_r      <= 1'b0;
    end
    else
    begin
      if (rx_err_i)
      begin
        comm_err_r <= 1'b1;
        perr_r     <= perr_nxt;
      end
      else if (frm_end & end_ok)
      begin
        comm_err_r <= 1'b0;
        perr_r     <= `HLR_PERR_NONE;
      end
      if (ovf_hit)
        ovf_r <= 1'b1;
      else if (frm_end & end_ok)
        ovf_r <= 1'b0;
    end
  end

  // Output drive; end code as two ASCII hex digits
  assign resp_valid_o    = resp_valid_r;
  assign resp_more_o     = resp_more_r;
  assign end_code_o      = {hex_enc(code_r[7:4]), hex_enc(code_r[3:0])};
  assign comm_err_o      = comm_err_r;
  assign port_err_code_o = perr_r;
  assign rx_overflow_o   = ovf_r;

endmodule
`default_nettype wire

// *** hlr_defs.svh ***
// Constants of the host link error responder: characters, limits, end codes, port error codes, FIFO shape
`ifndef HLR_DEFS_SVH
`define HLR_DEFS_SVH

// Frame characters
`define HLR_CH_START    8'h40
`define HLR_CH_CR       8'h0D
`define HLR_CH_TERM     8'h2A
`define HLR_CH_W        8'h57
`define HLR_CH_R        8'h52
`define HLR_CH_K        8'h4B
`define HLR_CH_F        8'h46
`define HLR_CH_S        8'h53
`define HLR_CH_C        8'h43
`define HLR_CH_P        8'h50
`define HLR_CH_M        8'h4D
`define HLR_CH_I        8'h49
`define HLR_CH_Q        8'h51
`define HLR_CH_HASH     8'h23
`define HLR_CH_DOLLAR   8'h24
`define HLR_CH_PCT      8'h25

// Frame limits and layout
`define HLR_FRAME_MAX   9'h084
`define HLR_OVF_LIMIT   9'h118
`define HLR_HDR_LEN     9'h005
`define HLR_NODE_MAX    8'h1F
`define HLR_WORD_CHARS  2'h0

// End codes, each nibble one ASCII hex digit of the response
`define HLR_EC_OK       8'h00
`define HLR_EC_RUN      8'h01
`define HLR_EC_MON      8'h02
`define HLR_EC_PM_WP    8'h03
`define HLR_EC_ADDR     8'h04
`define HLR_EC_CHK      8'h13
`define HLR_EC_FMT      8'h14
`define HLR_EC_DATA     8'h15
`define HLR_EC_OPND     8'h16
`define HLR_EC_LEN      8'h18
`define HLR_EC_NOREG    8'h19
`define HLR_EC_SW_WP    8'h23
`define HLR_EC_AB_CHK   8'hA3
`define HLR_EC_AB_FMT   8'hA4
`define HLR_EC_AB_DATA  8'hA5
`define HLR_EC_AB_LEN   8'hA8

// Serial port error codes
`define HLR_PERR_NONE   4'h0
`define HLR_PERR_PAR    4'h1
`define HLR_PERR_OVR    4'h2
`define HLR_PERR_FRM    4'h3

// Body FIFO shape
`define HLR_FIFO_WIDTH  8
`define HLR_FIFO_DEPTH  16

`endif

// *** hlr_pkg.sv ***
// Types of the host link error responder
package hlr_pkg;
  typedef enum logic [1:0] {
    HLR_ST_IDLE    = 2'b00,
    HLR_ST_BODY    = 2'b01,
    HLR_ST_DISCARD = 2'b10
  } hlr_state_t;

  typedef enum logic [1:0] {
    HLR_MODE_PRG = 2'b00,
    HLR_MODE_MON = 2'b01,
    HLR_MODE_RUN = 2'b10
  } hlr_mode_t;

  typedef enum logic [1:0] {
    HLR_RXE_PARITY  = 2'b00,
    HLR_RXE_OVERRUN = 2'b01,
    HLR_RXE_FRAMING = 2'b10
  } hlr_rxerr_t;
endpackage

// *** hlr_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module hlr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             core_clk_i,  // Core clock
  input  wire logic             reset_n_i,   // Synchronous reset, active low
  input  wire logic             in_valid_i,  // Write request
  output logic                  in_ready_o,  // Not full
  input  wire logic [WIDTH-1:0] in_data_i,   // Write data
  output logic                  out_valid_o, // Not empty
  input  wire logic             out_ready_i, // Read accept
  output logic      [WIDTH-1:0] out_data_o   // Head word
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      level_r;
  wire              push;
  wire              pop;

  // Handshake decode
  assign in_ready_o  = (level_r != DEPTH[AW:0]);
  assign out_valid_o = (level_r != '0);
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;
  assign out_data_o  = mem_r[rd_ptr_r];

  // Storage
  always_ff @(posedge core_clk_i)
  begin
    if (push)
    begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  // Pointers and fill level
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      level_r  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop)
        rd_ptr_r <= rd_ptr_r + 1'b1;
      level_r <= level_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule
`default_nettype wire

// *** hlr_responder_checker.sv ***
// Port-level assertions for the host link error responder
`timescale 1ns/100ps
`default_nettype none
module hlr_responder_checker (
  input wire logic                core_clk_i,     // Clock
  input wire logic                reset_n_i,      // Reset, active low
  input wire logic                rx_valid_i,     // Byte valid
  input wire logic [7:0]          rx_data_i,      // Byte
  input wire logic                rx_ready_o,     // Byte accepted
  input wire logic                rx_err_i,       // Line error
  input wire hlr_pkg::hlr_rxerr_t rx_err_kind_i,  // Error kind
  input wire logic                resp_valid_o,   // Response pulse
  input wire logic                resp_more_o,    // Intermediate ack
  input wire logic [15:0]         end_code_o,     // End code
  input wire logic                comm_err_o,     // Error bit
  input wire logic [3:0]          port_err_code_o // Error code
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  // Each end code character must be a hex digit
  wire logic hi_ok = end_code_o[15:8] inside {[8'h30:8'h39], [8'h41:8'h46]};
  wire logic lo_ok = end_code_o[7:0] inside {[8'h30:8'h39], [8'h41:8'h46]};
  a_resp_one_cycle: assert property (resp_valid_o |=> !resp_valid_o)
    else $error("response pulse longer than one cycle");
  a_code_holds: assert property (!resp_valid_o |-> $stable(end_code_o))
    else $error("end code changed without a response");
  a_code_hex: assert property (resp_valid_o |-> hi_ok && lo_ok)
    else $error("end code is not two hex characters");
  a_more_with_resp: assert property (resp_more_o |-> resp_valid_o)
    else $error("intermediate ack without response");
  a_resp_after_cr: assert property (resp_valid_o |->
    $past(rx_valid_i && rx_ready_o && !rx_err_i && rx_data_i == 8'h0D))
    else $error("response not preceded by a taken carriage return");
  a_err_sets_flag: assert property (rx_err_i |=> comm_err_o)
    else $error("line error did not set the error bit");
  a_err_code_kind: assert property (rx_err_i |=>
    port_err_code_o == {2'b00, $past(rx_err_kind_i)} + 4'h1)
    else $error("wrong port error code");
  a_err_no_resp: assert property (rx_err_i ##1 !rx_err_i |-> !resp_valid_o)
    else $error("response after a line error");
endmodule
`default_nettype wire

// *** hlr_host_model.sv ***
// Host computer model sending host link frames
`timescale 1ns/100ps
`default_nettype none
module hlr_host_model (
  input  wire logic       core_clk_i, // Clock
  input  wire logic       rx_ready_i, // Byte taken
  output logic            rx_valid_o, // Byte offered
  output logic      [7:0] rx_data_o   // Byte
);
  logic [7:0] q[$];
  logic       tk;
  // Upper case hex digit of a nibble
  function automatic logic [7:0] hx(input logic [3:0] v);
    return (v < 4'hA) ? 8'h30 + 8'(v) : 8'h37 + 8'(v);
  endfunction
  // Queue a frame, its check sequence, optional end mark and CR
  task automatic send(input string s, input bit fin, input bit bad);
    logic [7:0] f;
    f = 8'h00;
    foreach (s[i]) f ^= s[i];
    foreach (s[i]) q.push_back(s[i]);
    if (bad) f = ~f;
    q.push_back(hx(f[7:4]));
    q.push_back(hx(f[3:0]));
    if (fin) q.push_back(8'h2A);
    q.push_back(8'h0D);
  endtask
  initial
  begin
    rx_valid_o = 1'b0;
    rx_data_o  = 8'h00;
  end
  // Hold each byte until taken; idle data toggles
  always @(posedge core_clk_i)
  begin
    tk = rx_valid_o & rx_ready_i;
    #1;
    if (tk) void'(q.pop_front());
    rx_valid_o = (q.size() > 0);
    rx_data_o  = (q.size() > 0) ? q[0] : ~rx_data_o;
  end
endmodule
`default_nettype wire

// *** tb_hlr_responder.sv ***
// Self-checking bench of the host link error responder
`timescale 1ns/100ps
`default_nettype none
module tb_hlr_responder;
  typedef struct {string s; bit fin; bit bad; hlr_pkg::hlr_mode_t m; logic [5:0] f;
    logic [15:0] e;} hlr_case_t;
  localparam hlr_pkg::hlr_mode_t P = hlr_pkg::HLR_MODE_PRG;
  localparam hlr_pkg::hlr_mode_t M = hlr_pkg::HLR_MODE_MON;
  localparam hlr_pkg::hlr_mode_t R = hlr_pkg::HLR_MODE_RUN;
  logic core_clk_i, reset_n_i, rx_valid_i, rx_ready_o, rx_err_i, pm_protect_i, wp_switch_i;
  logic sv_addr_over_i, operand_miss_i, data_err_i, rd_registered_i, body_valid_o;
  logic body_ready_i, resp_valid_o, resp_more_o, comm_err_o, rx_overflow_o;
  logic [7:0] rx_data_i, body_data_o;
  logic [4:0] node_id_i;
  logic [3:0] port_err_code_o;
  logic [15:0] end_code_o;
  hlr_pkg::hlr_rxerr_t rx_err_kind_i;
  hlr_pkg::hlr_mode_t mode_i;
  int failures, tests_run;
  hlr_responder uut (.core_clk_i, .reset_n_i, .rx_valid_i, .rx_data_i, .rx_ready_o, .rx_err_i,
    .rx_err_kind_i, .node_id_i, .mode_i, .pm_protect_i, .wp_switch_i, .sv_addr_over_i,
    .operand_miss_i, .data_err_i, .rd_registered_i, .body_valid_o, .body_ready_i, .body_data_o,
    .resp_valid_o, .resp_more_o, .end_code_o, .comm_err_o, .port_err_code_o, .rx_overflow_o);
  hlr_host_model host (.core_clk_i, .rx_ready_i(rx_ready_o), .rx_valid_o(rx_valid_i),
    .rx_data_o(rx_data_i));
  // Compare and count
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic setc(input hlr_pkg::hlr_mode_t m, input logic [5:0] f);
    mode_i = m;
    {pm_protect_i, wp_switch_i, sv_addr_over_i, operand_miss_i, data_err_i, rd_registered_i} = f;
  endtask
  // Wait for a response; code zero means none may come
  task automatic wait_resp(input logic [15:0] e, input bit more);
    bit got;
    int n;
    got = 0;
    for (n = 0; n < 600 && !got; n++)
    begin
      @(posedge core_clk_i);
      #1;
      got = (resp_valid_o === 1'b1);
    end
    chk("resp_valid_o", 16'(e != 16'h0000), 16'(got));
    if (e != 16'h0000) chk("end_code_o", e, end_code_o);
    if (e != 16'h0000) chk("resp_more_o", 16'(more), 16'(resp_more_o));
  endtask
  task automatic exch(input string s, input bit fin, input bit bad, input logic [15:0] e,
    input bit more);
    host.send(s, fin, bad);
    wait_resp(e, more);
  endtask
  task automatic t_reset;
    chk("end_code_o", 16'h3030, end_code_o);
    chk("flags", 16'h0001, 16'({comm_err_o, port_err_code_o, rx_overflow_o, rx_ready_o}));
    $display("t_reset done");
  endtask
  task automatic t_codes;
    hlr_case_t c [18];
    c = '{'{"@00RR00000001", 1, 0, P, 6'h00, 16'h3030},
      '{"@00WR00000001", 1, 0, R, 6'h00, 16'h3031}, '{"@00WP00000000", 1, 0, M, 6'h00, 16'h3032},
      '{"@00WP00000000", 1, 0, P, 6'h20, 16'h3033}, '{"@00WP00000000", 1, 0, P, 6'h10, 16'h3233},
      '{"@00R#00000000", 1, 0, P, 6'h08, 16'h3034}, '{"@00RR00000001", 1, 1, P, 6'h00, 16'h3133},
      '{"@00RR00000001", 0, 0, P, 6'h00, 16'h3134}, '{"@00RR00000001", 1, 0, P, 6'h02, 16'h3135},
      '{"@00R#00000000", 1, 0, P, 6'h04, 16'h3136}, '{"@00QQIR", 1, 0, P, 6'h00, 16'h3139},
      '{"@00WP00000000", 1, 0, R, 6'h30, 16'h3031}, '{"@00RR00000001", 1, 1, P, 6'h02, 16'h3133},
      '{"00RR00000001", 1, 0, P, 6'h00, 16'h0000}, '{"@05RR00000001", 1, 0, P, 6'h00, 16'h0000},
      '{"@G0RR00000001", 1, 0, P, 6'h00, 16'h0000}, '{"@20RR00000001", 1, 0, P, 6'h00, 16'h0000},
      '{"@00RR00000001", 1, 0, P, 6'h00, 16'h3030}};
    foreach (c[i])
    begin
      setc(c[i].m, c[i].f);
      exch(c[i].s, c[i].fin, c[i].bad, c[i].e, 0);
    end
    $display("t_codes done");
  endtask
  task automatic t_split;
    hlr_case_t c [5];
    string l;
    l = "@00WR0000";
    repeat (35) l = {l, "0001"};
    c = '{'{"00020003", 1, 0, P, 6'h00, 16'h3030}, '{"00020003", 1, 1, P, 6'h00, 16'h4133},
      '{"00", 1, 0, P, 6'h00, 16'h4133}, '{"000200", 1, 0, P, 6'h00, 16'h4134},
      '{"00020003", 1, 0, P, 6'h02, 16'h4135}};
    exch(l, 1, 0, 16'h3138, 0);
    foreach (c[i])
    begin
      setc(P, 6'h00);
      exch("@00WR00000001", 0, 0, 16'h3030, 1);
      setc(c[i].m, c[i].f);
      exch(c[i].s, c[i].fin, c[i].bad, c[i].e, 0);
    end
    setc(P, 6'h00);
    exch("@00WR00000001", 0, 0, 16'h3030, 1);
    exch(l.substr(5, l.len() - 1), 1, 0, 16'h4138, 0);
    $display("t_split done");
  endtask
  task automatic t_line_err;
    for (int k = 0; k < 3; k++)
    begin
      @(posedge core_clk_i) #1 rx_err_kind_i = hlr_pkg::hlr_rxerr_t'(k);
      rx_err_i = 1;
      @(posedge core_clk_i);
      #1 rx_err_i = 0;
      chk("comm_err_o", 16'h0001, 16'(comm_err_o));
      chk("port_err_code_o", 16'(k + 1), 16'(port_err_code_o));
    end
    exch("@00RR00000001", 1, 0, 16'h3030, 0);
    @(posedge core_clk_i);
    #1 chk("comm_err_o", 16'h0000, 16'(comm_err_o));
    $display("t_line_err done");
  endtask
  task automatic t_ovf_fifo;
    string s;
    int n;
    s = "@00WR";
    repeat (73) s = {s, "0001"};
    exch(s, 1, 0, 16'h0000, 0);
    chk("rx_overflow_o", 16'h0001, 16'(rx_overflow_o));
    s = "@00WR0000";
    repeat (7) s = {s, "0001"};
    body_ready_i = 0;
    host.send(s, 1, 0);
    for (n = 0; n < 100 && rx_ready_o !== 1'b0; n++) @(posedge core_clk_i);
    chk("body_valid_o", 16'h0001, 16'(body_valid_o));
    for (n = 0; n < 16; n++)
    begin
      #1 chk("body_data_o", 16'(s[5 + n]), 16'(body_data_o));
      body_ready_i = 1;
      @(posedge core_clk_i);
      #1 body_ready_i = (n == 15);
    end
    wait_resp(16'h3030, 0);
    repeat (16) @(posedge core_clk_i);
    #1 chk("ovf_body", 16'h0000, 16'({rx_overflow_o, body_valid_o}));
    $display("t_ovf_fifo done");
  endtask
  task automatic complete_run;
    $display("Checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    core_clk_i = 0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  initial
  begin
    #480000 failures++;
    complete_run();
  end
  initial
  begin
    {failures, tests_run, reset_n_i, rx_err_i} = 0;
    rx_err_kind_i = hlr_pkg::HLR_RXE_PARITY;
    node_id_i = 5'h00;
    body_ready_i = 1;
    setc(P, 6'h00);
    repeat (6) @(posedge core_clk_i);
    #1 reset_n_i = 1;
    t_reset();
    t_codes();
    t_split();
    t_line_err();
    t_ovf_fifo();
    complete_run();
  end
endmodule
bind hlr_responder hlr_responder_checker chk (.core_clk_i, .reset_n_i, .rx_valid_i, .rx_data_i,
  .rx_ready_o, .rx_err_i, .rx_err_kind_i, .resp_valid_o, .resp_more_o, .end_code_o, .comm_err_o,
  .port_err_code_o);
`default_nettype wire
